// ===== rtl/exec_pkg.sv
// Shared constants and carrier types for the instruction execution subset.
// Assumes one core clock; decoder presents one instruction per issue pulse.
package exec_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned NIB_LO_MSB = 3;
   localparam int unsigned NIB_HI_LSB = 4;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] WDT_CLEAR_VAL = 8'h00;
   localparam logic [7:0] DIR_RESET_VAL = 8'hFF;
   localparam logic [2:0] DIR_SEL_A = 3'h5;
   localparam logic [2:0] DIR_SEL_B = 3'h6;
   localparam logic [2:0] DIR_SEL_C = 3'h7;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   typedef enum logic [2:0] {
      OP_NONE      = 3'b000,
      OP_SLEEP     = 3'b001,
      OP_SUB       = 3'b010,
      OP_SUB_BRW   = 3'b011,
      OP_SWAP      = 3'b100,
      OP_DIR_LOAD  = 3'b101,
      OP_XOR_LIT   = 3'b110,
      OP_XOR_FILE  = 3'b111
   } op_t;

   // Instruction as handed over by the decoder
   typedef struct packed {
      op_t                 op;
      logic                dest;
      logic [FADDR_W-1:0]  faddr;
      logic [DATA_W-1:0]   literal;
   } instr_t;

   // Status flags touched by this subset
   typedef struct packed {
      logic expiry;
      logic sleep_entered_n;
      logic nil;
      logic nibble_borrow;
      logic arith_out;
   } flags_t;

   // Result of the arithmetic unit
   typedef struct packed {
      logic [DATA_W-1:0] value;
      logic              arith_out;
      logic              nibble_borrow;
      logic              nil;
   } alu_res_t;
endpackage

// ===== rtl/sub_xor_unit.sv
// Combinational subtract, swap and xor unit for the execution subset.
// Assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/1ns
`default_nettype none
module sub_xor_unit #(
   parameter int unsigned WIDTH = 8
) (
   // Operands
   input  wire logic [2:0]          op_i,
   input  wire logic [WIDTH-1:0]    file_i,
   input  wire logic [WIDTH-1:0]    acc_i,
   input  wire logic [WIDTH-1:0]    literal_i,
   input  wire logic                arith_out_i,
   // Result
   output exec_pkg::alu_res_t       res_o
);
   logic [WIDTH:0]   diff;
   logic [4:0]       nib_diff;
   logic             brw_in;
   logic [WIDTH-1:0] val;

   always_comb begin
      brw_in = 1'b0;
      if (op_i == exec_pkg::OP_SUB_BRW) begin
         brw_in = ~arith_out_i;
      end
      // Extra top bit captures the borrow out of bit 7
      diff = {1'b0, file_i} - {1'b0, acc_i} - {{WIDTH{1'b0}}, brw_in};
      nib_diff = {1'b0, file_i[exec_pkg::NIB_LO_MSB:0]}
               - {1'b0, acc_i[exec_pkg::NIB_LO_MSB:0]}
               - {4'h0, brw_in};
      case (op_i)
         exec_pkg::OP_SUB,
         exec_pkg::OP_SUB_BRW: val = diff[WIDTH-1:0];
         exec_pkg::OP_SWAP: val = {file_i[exec_pkg::NIB_LO_MSB:0],
                                   file_i[WIDTH-1:exec_pkg::NIB_HI_LSB]};
         exec_pkg::OP_XOR_LIT: val = acc_i ^ literal_i;
         exec_pkg::OP_XOR_FILE: val = acc_i ^ file_i;
         default: val = acc_i;
      endcase
      res_o.value = val;
      res_o.arith_out = ~diff[WIDTH];
      res_o.nibble_borrow = ~nib_diff[4];
      res_o.nil = (val == exec_pkg::ZERO_BYTE);
   end
endmodule
`default_nettype wire

// ===== rtl/instr_exec_core.sv
// Execution stage for a subset of an 8-bit core's instructions.
// Assumes the decoder issues one instruction per issue pulse and supplies
// the addressed file register value in the same cycle.
//
// Overview of operation
// - Sleep clears the watchdog counter to zero and its prescaler.
// - Sleep clears the sleep-entered flag and sets the expiry flag.
// - After sleep the core halts, oscillator stopped, no execution until wake_i.
// - Subtract computes file minus accumulator; dest 0 to acc, 1 to file.
// - Subtract sets carry unless acc exceeds file; nibble flag likewise.
// - Subtract with borrow takes file minus acc minus inverted carry.
// - Subtract with borrow writes acc for dest 0 and file for dest 1.
// - Nibble swap exchanges the halves, dest selectable, flags untouched.
// - Direction load copies acc to port A, B or C direction for 5, 6, 7.
// - Xor literal updates acc with acc xor literal, only nil flag changes.
// - Xor file writes acc xor file to acc for dest 0, file for dest 1.
`timescale 1ns/1ns
`default_nettype none
module instr_exec_core #(
   parameter int unsigned WIDTH   = 8,
   parameter int unsigned FADDR_W = 7
) (
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 srst_i,
   // Instruction issue
   input  wire logic                 issue_i,
   input  wire exec_pkg::instr_t     instr_i,
   input  wire logic [WIDTH-1:0]     file_rd_data_i,
   input  wire logic                 wake_i,
   // Watchdog event from the timer logic
   input  wire logic                 wdt_tick_i,
   // File register write-back
   output logic                      file_wr_o,
   output logic [FADDR_W-1:0]        file_wr_addr_o,
   output logic [WIDTH-1:0]          file_wr_data_o,
   // Architectural state
   output logic [WIDTH-1:0]          acc_o,
   output exec_pkg::flags_t          flags_o,
   output logic [WIDTH-1:0]          port_a_direction_o,
   output logic [WIDTH-1:0]          port_b_direction_o,
   output logic [WIDTH-1:0]          port_c_direction_o,
   // Watchdog and power state
   output logic [WIDTH-1:0]          watchdog_counter_o,
   output logic [WIDTH-1:0]          wdt_prescaler_o,
   output logic                      osc_run_o,
   output logic                      busy_o
);
   typedef enum logic [0:0] {
      ST_RUN   = 1'b0,
      ST_SLEEP = 1'b1
   } pwr_state_t;

   pwr_state_t         state_ff;
   // Separate flop so the run indication leaves the block registered
   logic               run_ff;
   logic [WIDTH-1:0]   acc_ff;
   exec_pkg::flags_t   flags_ff;
   logic [WIDTH-1:0]   dir_a_ff;
   logic [WIDTH-1:0]   dir_b_ff;
   logic [WIDTH-1:0]   dir_c_ff;
   logic [WIDTH-1:0]   wdt_ff;
   logic [WIDTH-1:0]   presc_ff;
   logic               fwr_ff;
   logic [FADDR_W-1:0] faddr_ff;
   logic [WIDTH-1:0]   fdata_ff;
   exec_pkg::alu_res_t res;
   logic               exec_en;
   logic               is_sub;
   logic               writes_dest;

   // Nothing executes while asleep
   assign exec_en = issue_i && (state_ff == ST_RUN);
   assign is_sub = (instr_i.op == exec_pkg::OP_SUB)
                || (instr_i.op == exec_pkg::OP_SUB_BRW);
   assign writes_dest = is_sub
                     || (instr_i.op == exec_pkg::OP_SWAP)
                     || (instr_i.op == exec_pkg::OP_XOR_FILE);

   sub_xor_unit #(
      .WIDTH (WIDTH)
   ) u_alu (
      .op_i        (instr_i.op),
      .file_i      (file_rd_data_i),
      .acc_i       (acc_ff),
      .literal_i   (instr_i.literal),
      .arith_out_i (flags_ff.arith_out),
      .res_o       (res)
   );

   // Power state: wake only through an external event
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_ff <= ST_RUN;
         run_ff <= 1'b1;
      end else begin
         case (state_ff)
            ST_RUN: begin
               if (exec_en && instr_i.op == exec_pkg::OP_SLEEP) begin
                  state_ff <= ST_SLEEP;
                  run_ff <= 1'b0;
               end
            end
            ST_SLEEP: begin
               if (wake_i) begin
                  state_ff <= ST_RUN;
                  run_ff <= 1'b1;
               end
            end
            default: begin
               state_ff <= ST_RUN;
               run_ff <= 1'b1;
            end
         endcase
      end
   end

   // Accumulator
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         acc_ff <= exec_pkg::ZERO_BYTE;
      end else if (exec_en) begin
         if (instr_i.op == exec_pkg::OP_XOR_LIT) begin
            acc_ff <= res.value;
         end else if (writes_dest && instr_i.dest == exec_pkg::DEST_ACC) begin
            acc_ff <= res.value;
         end
      end
   end

   // File register write-back, one cycle after issue
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         fwr_ff <= 1'b0;
         faddr_ff <= '0;
         fdata_ff <= exec_pkg::ZERO_BYTE;
      end else begin
         fwr_ff <= exec_en && writes_dest
                && (instr_i.dest == exec_pkg::DEST_FILE);
         if (exec_en && writes_dest) begin
            faddr_ff <= instr_i.faddr;
            fdata_ff <= res.value;
         end
      end
   end

   // Status flags
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         flags_ff <= '{expiry: 1'b1, sleep_entered_n: 1'b1, nil: 1'b0,
                       nibble_borrow: 1'b0, arith_out: 1'b0};
      end else if (exec_en) begin
         case (instr_i.op)
            exec_pkg::OP_SLEEP: begin
               flags_ff.sleep_entered_n <= 1'b0;
               flags_ff.expiry <= 1'b1;
            end
            exec_pkg::OP_SUB,
            exec_pkg::OP_SUB_BRW: begin
               flags_ff.arith_out <= res.arith_out;
               flags_ff.nibble_borrow <= res.nibble_borrow;
               flags_ff.nil <= res.nil;
            end
            exec_pkg::OP_XOR_LIT,
            exec_pkg::OP_XOR_FILE: begin
               flags_ff.nil <= res.nil;
            end
            default: begin
               // Swap and direction load leave flags alone
            end
         endcase
      end
   end

   // Port direction registers
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         dir_a_ff <= exec_pkg::DIR_RESET_VAL;
         dir_b_ff <= exec_pkg::DIR_RESET_VAL;
         dir_c_ff <= exec_pkg::DIR_RESET_VAL;
      end else if (exec_en && instr_i.op == exec_pkg::OP_DIR_LOAD) begin
         // Operands whose low three bits are outside 5..7 are ignored
         case (instr_i.faddr[2:0])
            exec_pkg::DIR_SEL_A: dir_a_ff <= acc_ff;
            exec_pkg::DIR_SEL_B: dir_b_ff <= acc_ff;
            exec_pkg::DIR_SEL_C: dir_c_ff <= acc_ff;
            default: begin
            end
         endcase
      end
   end

   // Watchdog counter and prescaler; sleep clearing wins over a tick
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         wdt_ff <= exec_pkg::WDT_CLEAR_VAL;
         presc_ff <= exec_pkg::WDT_CLEAR_VAL;
      end else if (exec_en && instr_i.op == exec_pkg::OP_SLEEP) begin
         wdt_ff <= exec_pkg::WDT_CLEAR_VAL;
         presc_ff <= exec_pkg::WDT_CLEAR_VAL;
      end else if (wdt_tick_i) begin
         presc_ff <= presc_ff + 8'h01;
         if (&presc_ff) begin
            wdt_ff <= wdt_ff + 8'h01;
         end
      end
   end

   assign acc_o = acc_ff;
   assign flags_o = flags_ff;
   assign port_a_direction_o = dir_a_ff;
   assign port_b_direction_o = dir_b_ff;
   assign port_c_direction_o = dir_c_ff;
   assign watchdog_counter_o = wdt_ff;
   assign wdt_prescaler_o = presc_ff;
   assign file_wr_o = fwr_ff;
   assign file_wr_addr_o = faddr_ff;
   assign file_wr_data_o = fdata_ff;
   assign osc_run_o = run_ff;
   assign busy_o = run_ff;
endmodule
`default_nettype wire

// ===== tb/exec_core_sva.sv
// Checker for the execution subset, bound to instr_exec_core.
// Sees only the core's ports; one clock with a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module exec_core_sva #(
   parameter int unsigned WIDTH   = 8,
   parameter int unsigned FADDR_W = 7
) (
   // Inputs of the core
   input wire logic               sys_clk_i,
   input wire logic               srst_i,
   input wire logic               issue_i,
   input wire exec_pkg::instr_t   instr_i,
   input wire logic [WIDTH-1:0]   file_rd_data_i,
   // Outputs of the core
   input wire logic               file_wr_o,
   input wire logic [WIDTH-1:0]   file_wr_data_o,
   input wire logic [WIDTH-1:0]   acc_o,
   input wire exec_pkg::flags_t   flags_o,
   input wire logic [WIDTH-1:0]   port_a_direction_o,
   input wire logic [WIDTH-1:0]   watchdog_counter_o,
   input wire logic [WIDTH-1:0]   wdt_prescaler_o,
   input wire logic               osc_run_o
);
   logic go;
   exec_pkg::op_t op;
   assign go = issue_i && osc_run_o;
   assign op = instr_i.op;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   chk_sleep_wdt: assert property (go && op == exec_pkg::OP_SLEEP
      |=> watchdog_counter_o == '0 && wdt_prescaler_o == '0)
      else $error("watchdog not cleared by sleep");
   chk_sleep_flags: assert property (go && op == exec_pkg::OP_SLEEP
      |=> flags_o.expiry && !flags_o.sleep_entered_n)
      else $error("sleep flags wrong");
   chk_sleep_halt: assert property (go && op == exec_pkg::OP_SLEEP
      |=> !osc_run_o) else $error("core still running after sleep");
   chk_halt_holds: assert property (issue_i && !osc_run_o
      |=> $stable(acc_o)) else $error("instruction ran while asleep");
   chk_sub_write: assert property (go && op == exec_pkg::OP_SUB
      && instr_i.dest |=> file_wr_o
      && file_wr_data_o == $past(file_rd_data_i) - $past(acc_o))
      else $error("subtract write-back wrong");
   chk_swap_flags: assert property (go && op == exec_pkg::OP_SWAP
      |=> flags_o == $past(flags_o)) else $error("swap touched flags");
   chk_dir_a: assert property (go && op == exec_pkg::OP_DIR_LOAD
      && instr_i.faddr[2:0] == 3'h5 |=> port_a_direction_o == $past(acc_o))
      else $error("port a direction not loaded");
   chk_xor_lit: assert property (go && op == exec_pkg::OP_XOR_LIT
      |=> acc_o == ($past(acc_o) ^ $past(instr_i.literal)))
      else $error("xor literal result wrong");
   chk_nil_flag: assert property (go && op == exec_pkg::OP_XOR_LIT
      |=> flags_o.nil == (acc_o == '0)) else $error("nil flag wrong");
endmodule
bind instr_exec_core exec_core_sva #(.WIDTH(WIDTH), .FADDR_W(FADDR_W)) u_sva (
   .sys_clk_i(sys_clk_i), .srst_i(srst_i), .issue_i(issue_i),
   .instr_i(instr_i), .file_rd_data_i(file_rd_data_i),
   .file_wr_o(file_wr_o), .file_wr_data_o(file_wr_data_o), .acc_o(acc_o),
   .flags_o(flags_o), .port_a_direction_o(port_a_direction_o),
   .watchdog_counter_o(watchdog_counter_o),
   .wdt_prescaler_o(wdt_prescaler_o), .osc_run_o(osc_run_o));
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for instr_exec_core.
// Drives the decoder side directly; expectations come from a local model.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import exec_pkg::*;
   typedef struct packed {
      op_t op; logic dest; logic [6:0] fa; logic [7:0] lit; logic [7:0] f;
   } row_t;
   logic sys_clk_i = 0, srst_i = 1, issue_i = 0, wake_i = 0, wdt_tick_i = 0;
   instr_t instr_i = '0;
   logic [7:0] file_rd_data_i = 8'h00, acc_o, pa, pb, pc, wdc, wdp, wdata;
   logic [6:0] waddr;
   logic file_wr_o, osc_run_o, busy;
   flags_t flags_o, e_fl;
   logic [7:0] e_acc;
   logic [23:0] e_dir;
   int err_count = 0, n_tests = 0, cyc = 0;
   row_t rows[16] = '{
      '{OP_XOR_LIT, 0, 7'h00, 8'h3C, 8'h00}, '{OP_SUB, 0, 7'h10, 8'h00, 8'h50},
      '{OP_SUB, 1, 7'h11, 8'h00, 8'h14}, '{OP_SUB_BRW, 0, 7'h12, 8'h00, 8'h20},
      '{OP_SUB, 0, 7'h13, 8'h00, 8'h05}, '{OP_SUB_BRW, 1, 7'h14, 8'h00, 8'hF8},
      '{OP_SUB_BRW, 0, 7'h15, 8'h00, 8'h00}, '{OP_SWAP, 0, 7'h16, 8'h00, 8'hA5},
      '{OP_SWAP, 1, 7'h17, 8'h00, 8'h3C}, '{OP_DIR_LOAD, 0, 7'h05, 8'h00, 8'h00},
      '{OP_XOR_FILE, 0, 7'h18, 8'h00, 8'h0F}, '{OP_DIR_LOAD, 0, 7'h06, 8'h00, 8'h00},
      '{OP_XOR_FILE, 1, 7'h19, 8'h00, 8'hFF}, '{OP_DIR_LOAD, 0, 7'h07, 8'h00, 8'h00},
      '{OP_DIR_LOAD, 0, 7'h04, 8'h00, 8'h00}, '{OP_XOR_LIT, 0, 7'h00, 8'h55, 8'h00}};
   instr_exec_core dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .issue_i(issue_i),
      .instr_i(instr_i), .file_rd_data_i(file_rd_data_i), .wake_i(wake_i),
      .wdt_tick_i(wdt_tick_i), .file_wr_o(file_wr_o), .file_wr_addr_o(waddr),
      .file_wr_data_o(wdata), .acc_o(acc_o), .flags_o(flags_o),
      .port_a_direction_o(pa), .port_b_direction_o(pb),
      .port_c_direction_o(pc), .watchdog_counter_o(wdc),
      .wdt_prescaler_o(wdp), .osc_run_o(osc_run_o), .busy_o(busy));
   initial forever #10 sys_clk_i = ~sys_clk_i;
   task automatic stop_test;
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic run(input row_t r);
      logic b, wr;
      logic [8:0] d9;
      logic [4:0] d5;
      logic [7:0] res;
      b = (r.op == OP_SUB_BRW) ? ~e_fl.arith_out : 1'b0;
      d9 = {1'b0, r.f} - {1'b0, e_acc} - 9'(b);
      d5 = {1'b0, r.f[3:0]} - {1'b0, e_acc[3:0]} - 5'(b);
      res = d9[7:0];
      if (r.op == OP_SWAP) res = {r.f[3:0], r.f[7:4]};
      if (r.op == OP_XOR_LIT) res = e_acc ^ r.lit;
      if (r.op == OP_XOR_FILE) res = e_acc ^ r.f;
      if (r.op inside {OP_SUB, OP_SUB_BRW}) begin
         e_fl.arith_out = ~d9[8];
         e_fl.nibble_borrow = ~d5[4];
      end
      if (r.op inside {OP_SUB, OP_SUB_BRW, OP_XOR_LIT, OP_XOR_FILE})
         e_fl.nil = (res == 8'h00);
      if (r.op == OP_SLEEP) e_fl[4:3] = 2'b10;
      if (r.op == OP_DIR_LOAD && r.fa[2:0] >= 3'h5)
         e_dir[8*(7-r.fa[2:0]) +: 8] = e_acc;
      wr = r.dest && r.op inside {OP_SUB, OP_SUB_BRW, OP_SWAP, OP_XOR_FILE};
      if (!wr && !(r.op inside {OP_DIR_LOAD, OP_SLEEP})) e_acc = res;
      @(posedge sys_clk_i);
      issue_i <= 1'b1;
      instr_i <= '{r.op, r.dest, r.fa, r.lit};
      file_rd_data_i <= r.f;
      @(posedge sys_clk_i);
      issue_i <= 1'b0;
      file_rd_data_i <= ~r.f;
      #1;
      cmp(24'(acc_o), 24'(e_acc), "acc");
      cmp(24'(flags_o), 24'(e_fl), "flags");
      cmp({pa, pb, pc}, e_dir, "dir");
      cmp(24'(file_wr_o), 24'(wr), "wr");
      if (wr) cmp({waddr, wdata}, {r.fa, res}, "wdata");
   endtask
   task automatic check_reset;
      e_acc = 8'h00;
      e_fl = 5'b11000;
      e_dir = 24'hFFFFFF;
      cmp({acc_o, wdc, wdp}, 24'h0, "reset acc wdt");
      cmp({flags_o, file_wr_o, osc_run_o}, 7'b1100001, "reset flags");
      cmp({pa, pb, pc}, e_dir, "reset dir");
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      #1 check_reset();
      foreach (rows[i]) run(rows[i]);
      // Sleep lands while the watchdog is ticking; the clear must win
      @(posedge sys_clk_i) wdt_tick_i <= 1'b1;
      repeat (300) @(posedge sys_clk_i);
      run('{OP_SLEEP, 0, 7'h00, 8'h00, 8'h00});
      cmp({wdc, wdp, 6'h0, busy, osc_run_o}, 24'h0, "sleep wdt");
      @(posedge sys_clk_i) issue_i <= 1'b1;
      wdt_tick_i <= 1'b0;
      instr_i <= '{OP_XOR_LIT, 1'b0, 7'h00, 8'hA0};
      @(posedge sys_clk_i) issue_i <= 1'b0;
      wake_i <= 1'b1;
      @(posedge sys_clk_i) wake_i <= 1'b0;
      #1 cmp(24'(acc_o), 24'(e_acc), "asleep acc");
      cmp(24'(flags_o), 24'(e_fl), "asleep flags");
      cmp(24'({busy, osc_run_o}), 24'h3, "woken");
      run(rows[0]);
      @(posedge sys_clk_i) srst_i <= 1'b1;
      @(posedge sys_clk_i) srst_i <= 1'b0;
      #1 check_reset();
      stop_test();
   end
endmodule
`default_nettype wire
